/* File: smx_pkg.sv */
// smx_pkg: shared constants and types for the system-register move and mac execute block
// assumes a big-endian bit numbering convention translated to [31:0] by the decoder
package smx_pkg;
  localparam logic [5:0]  SMX_OP_MAC      = 6'h04;
  localparam logic [5:0]  SMX_OP_X31      = 6'h1f;
  localparam logic [8:0]  SMX_XO_MACLHWU  = 9'h18c;
  localparam logic [9:0]  SMX_XO_MCRF     = 10'h000;
  localparam logic [9:0]  SMX_XO_MCRXR    = 10'h200;
  localparam logic [9:0]  SMX_XO_MFCR     = 10'h013;
  localparam logic [9:0]  SMX_XO_MFDCR    = 10'h143;
  localparam logic [9:0]  SMX_XO_MFMSR    = 10'h053;
  localparam logic [9:0]  SMX_XO_MFSPR    = 10'h153;
  localparam logic [9:0]  SMX_XO_MFTB     = 10'h173;
  localparam logic [9:0]  SMX_XO_MTCRF    = 10'h090;
  localparam logic [9:0]  SMX_XO_MTDCR    = 10'h1c3;
  localparam logic [9:0]  SMX_XO_MTMSR    = 10'h092;
  localparam logic [9:0]  SMX_XO_MTSPR    = 10'h1d3;
  localparam logic [9:0]  SMX_TBN_LOW     = 10'h10c;
  localparam logic [9:0]  SMX_TBN_HIGH    = 10'h10d;
  localparam logic [31:0] SMX_CR_RESET    = 32'h0000_0000;
  localparam logic [31:0] SMX_XER_RESET   = 32'h0000_0000;
  localparam logic [31:0] SMX_MSR_RESET   = 32'h0000_0000;
  localparam int          SMX_MSR_PR_BIT  = 14;
  localparam int          SMX_XER_SO_BIT  = 31;
  localparam int          SMX_XER_OV_BIT  = 30;
  localparam int          SMX_XER_CA_BIT  = 29;

  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [31:0] src_a;
    logic [31:0] src_b;
    logic [31:0] dest_old;
  } smx_issue_t;

  typedef struct packed {
    logic        wr;
    logic [9:0]  num;
    logic [31:0] data;
  } smx_sysreg_wr_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  idx;
    logic [31:0] data;
  } smx_gpr_wr_t;
endpackage

/* File: smx_exec.sv */
// smx_exec: executes unsigned low-halfword mac and moves to and from system registers
// assumes one instruction offered per cycle with operands already read; result one cycle later
`timescale 1ns/1ps
// Notes on behaviour
// - mac 396 multiplies low halfwords unsigned, adds destination, keeps low 32 bits.
// - overflow-enable updates sticky and overflow; record bit updates field zero flags.
// - copy one condition field into another, others unchanged.
// - exception bits 0..3 copy positionally into the chosen condition field.
// - with instruction bit 31 set, field zero may be left undefined.
// - reading condition flags returns whole 32-bit register.
// - device register read number is field bits 5:9 ahead of 0:4.
// - device register write 451 uses the same swapped number.
// - device register access and machine state read need privileged mode.
// - machine state read 83 copies the whole register to destination.
// - machine state write loads source; privileged and execution synchronizing.
// - special read decodes swapped number; privileged only when instruction bit 11 set.
// - special write decodes swapped number; privileged only when bit 11 set.
// - time base read returns low word for 268, high word for 269.
// - other time base numbers give undefined data and disturb nothing.
// - eight mask bits each gate four condition bits on field write.
module smx_exec (
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  input  wire smx_pkg::smx_issue_t     issue_i,
  input  wire logic [31:0]             dcr_rdata_i,
  input  wire logic [31:0]             spr_rdata_i,
  input  wire logic [63:0]             time_base_i,
  output logic                         gpr_wr_valid_o,
  output logic [4:0]                   gpr_wr_idx_o,
  output logic [31:0]                  gpr_wr_data_o,
  output logic [9:0]                   dcr_rnum_o,
  output logic [9:0]                   spr_rnum_o,
  output smx_pkg::smx_sysreg_wr_t      dcr_wr_o,
  output smx_pkg::smx_sysreg_wr_t      spr_wr_o,
  output logic                         priv_exc_o,
  output logic                         sync_o,
  output logic [31:0]                  cr_o,
  output logic [31:0]                  xer_o,
  output logic [31:0]                  msr_o
);
  logic [31:0] cr_ff;
  logic [31:0] xer_ff;
  logic [31:0] msr_ff;
  logic [31:0] nxt_cr;
  logic [31:0] nxt_xer;
  logic [31:0] nxt_msr;
  smx_pkg::smx_gpr_wr_t    gpr_ff;
  smx_pkg::smx_gpr_wr_t    nxt_gpr;
  smx_pkg::smx_sysreg_wr_t dcr_wr_ff;
  smx_pkg::smx_sysreg_wr_t spr_wr_ff;
  logic [9:0]  dcr_rnum_ff;
  logic [9:0]  spr_rnum_ff;
  logic        priv_exc_ff;
  logic        sync_ff;

  // msb-first instruction fields, re-indexed to [31:0]
  wire [31:0] ins       = issue_i.instr;
  wire [5:0]  opcd      = ins[31:26];
  wire [4:0]  rt_idx    = ins[25:21];
  wire [9:0]  xo10      = ins[10:1];
  wire [8:0]  xo9       = ins[9:1];
  wire        oe_bit    = ins[10];
  wire        record_bit = ins[0];
  wire        ins_bit11 = ins[20];
  wire [2:0]  dest_field_sel = ins[25:23];
  wire [2:0]  src_field_sel  = ins[20:18];
  wire [7:0]  field_copy_mask = ins[19:12];
  wire [9:0]  reg_num_field  = ins[20:11];
  // field bits 0:4 sit in ins[20:16], 5:9 in ins[15:11]; swap halves
  wire [9:0]  swapped_num    = {reg_num_field[4:0], reg_num_field[9:5]};
  wire        user_mode      = msr_ff[smx_pkg::SMX_MSR_PR_BIT];

  wire is_x31   = issue_i.valid && (opcd == smx_pkg::SMX_OP_X31);
  wire is_mac   = issue_i.valid && (opcd == smx_pkg::SMX_OP_MAC) && (xo9 == smx_pkg::SMX_XO_MACLHWU);
  wire is_mcrf  = issue_i.valid && (opcd == 6'h13) && (xo10 == smx_pkg::SMX_XO_MCRF);
  wire is_mcrxr = is_x31 && (xo10 == smx_pkg::SMX_XO_MCRXR);
  wire is_mfcr  = is_x31 && (xo10 == smx_pkg::SMX_XO_MFCR);
  wire is_mfdcr = is_x31 && (xo10 == smx_pkg::SMX_XO_MFDCR);
  wire is_mfmsr = is_x31 && (xo10 == smx_pkg::SMX_XO_MFMSR);
  wire is_mfspr = is_x31 && (xo10 == smx_pkg::SMX_XO_MFSPR);
  wire is_mftb  = is_x31 && (xo10 == smx_pkg::SMX_XO_MFTB);
  wire is_mtcrf = is_x31 && (xo10 == smx_pkg::SMX_XO_MTCRF);
  wire is_mtdcr = is_x31 && (xo10 == smx_pkg::SMX_XO_MTDCR);
  wire is_mtmsr = is_x31 && (xo10 == smx_pkg::SMX_XO_MTMSR);
  wire is_mtspr = is_x31 && (xo10 == smx_pkg::SMX_XO_MTSPR);

  wire needs_priv = is_mfdcr || is_mtdcr || is_mfmsr || is_mtmsr
                  || ((is_mfspr || is_mtspr) && ins_bit11);
  wire priv_fault = needs_priv && user_mode;
  wire go         = !priv_fault;

  // mac: low halves unsigned, 33-bit sum
  wire [31:0] mac_prod = {16'h0000, issue_i.src_a[15:0]} * {16'h0000, issue_i.src_b[15:0]};
  wire [32:0] mac_sum  = {1'b0, mac_prod} + {1'b0, issue_i.dest_old};
  wire [31:0] mac_res  = mac_sum[31:0];
  wire        mac_ov   = mac_sum[32];
  wire        so_now   = oe_bit ? (xer_ff[smx_pkg::SMX_XER_SO_BIT] | mac_ov) : xer_ff[smx_pkg::SMX_XER_SO_BIT];
  wire        res_lt   = mac_res[31];
  wire        res_eq   = (mac_res == 32'h0000_0000);
  wire [3:0]  mac_cr0  = {res_lt, !res_lt && !res_eq, res_eq, so_now};

  // field index 0 is the most significant nibble
  wire [4:0]  src_sh   = 5'(5'd28 - {src_field_sel, 2'b00});
  wire [4:0]  dst_sh   = 5'(5'd28 - {dest_field_sel, 2'b00});
  wire [3:0]  src_nib  = 4'(cr_ff >> src_sh);
  wire [31:0] dst_mask = 32'(32'h0000_000f << dst_sh);
  wire [31:0] cr_mcrf  = (cr_ff & ~dst_mask) | (32'({28'h000_0000, src_nib} << dst_sh));
  wire [3:0]  xer_nib  = xer_ff[31:28];
  wire [31:0] cr_mcrxr = (cr_ff & ~dst_mask) | (32'({28'h000_0000, xer_nib} << dst_sh));

  logic [31:0] crf_mask;
  always_comb begin
    crf_mask = 32'h0000_0000;
    for (int i = 0; i < 8; i++) begin
      crf_mask[31 - 4*i -: 4] = {4{field_copy_mask[7 - i]}};
    end
  end
  wire [31:0] cr_mtcrf = (issue_i.src_a & crf_mask) | (cr_ff & ~crf_mask);

  // time base: unknown numbers return zero and touch nothing else
  wire [31:0] tb_data = (swapped_num == smx_pkg::SMX_TBN_LOW)  ? time_base_i[31:0]  :
                        (swapped_num == smx_pkg::SMX_TBN_HIGH) ? time_base_i[63:32] :
                        32'h0000_0000;

  always_comb begin
    nxt_cr  = cr_ff;
    nxt_xer = xer_ff;
    nxt_msr = msr_ff;
    nxt_gpr = '{valid: 1'b0, idx: rt_idx, data: 32'h0000_0000};
    if (go) begin
      if (is_mac) begin
        nxt_gpr.valid = 1'b1;
        nxt_gpr.data  = mac_res;
        if (oe_bit) begin
          nxt_xer[smx_pkg::SMX_XER_OV_BIT] = mac_ov;
          nxt_xer[smx_pkg::SMX_XER_SO_BIT] = so_now;
        end
        if (record_bit) begin
          nxt_cr[31:28] = mac_cr0;
        end
      end
      if (is_mcrf) begin
        nxt_cr = cr_mcrf;
      end
      if (is_mcrxr) begin
        nxt_cr = cr_mcrxr;
        nxt_xer[31:29] = 3'b000;
      end
      if (is_mtcrf) begin
        nxt_cr = cr_mtcrf;
      end
      if (is_mtmsr) begin
        nxt_msr = issue_i.src_a;
      end
      if (is_mfcr) begin
        nxt_gpr.valid = 1'b1;
        nxt_gpr.data  = cr_ff;
      end
      if (is_mfmsr) begin
        nxt_gpr.valid = 1'b1;
        nxt_gpr.data  = msr_ff;
      end
      if (is_mfdcr) begin
        nxt_gpr.valid = 1'b1;
        nxt_gpr.data  = dcr_rdata_i;
      end
      if (is_mfspr) begin
        nxt_gpr.valid = 1'b1;
        nxt_gpr.data  = spr_rdata_i;
      end
      if (is_mftb) begin
        nxt_gpr.valid = 1'b1;
        nxt_gpr.data  = tb_data;
      end
    end
    // bit 31 set on moves leaves field zero as it was, one legal choice for undefined
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cr_ff       <= smx_pkg::SMX_CR_RESET;
      xer_ff      <= smx_pkg::SMX_XER_RESET;
      msr_ff      <= smx_pkg::SMX_MSR_RESET;
      gpr_ff      <= '0;
      dcr_wr_ff   <= '0;
      spr_wr_ff   <= '0;
      dcr_rnum_ff <= 10'h000;
      spr_rnum_ff <= 10'h000;
      priv_exc_ff <= 1'b0;
      sync_ff     <= 1'b0;
    end else begin
      cr_ff       <= nxt_cr;
      xer_ff      <= nxt_xer;
      msr_ff      <= nxt_msr;
      gpr_ff      <= nxt_gpr;
      dcr_wr_ff   <= '{wr: is_mtdcr && go, num: swapped_num, data: issue_i.src_a};
      spr_wr_ff   <= '{wr: is_mtspr && go, num: swapped_num, data: issue_i.src_a};
      dcr_rnum_ff <= swapped_num;
      spr_rnum_ff <= swapped_num;
      priv_exc_ff <= priv_fault;
      sync_ff     <= is_mtmsr && go;
    end
  end

  // read numbers go out combinationally too early for a registered port, so the
  // registered copy is offered and the read data is sampled in the issue cycle
  assign gpr_wr_valid_o = gpr_ff.valid;
  assign gpr_wr_idx_o   = gpr_ff.idx;
  assign gpr_wr_data_o  = gpr_ff.data;
  assign dcr_rnum_o     = dcr_rnum_ff;
  assign spr_rnum_o     = spr_rnum_ff;
  assign dcr_wr_o       = dcr_wr_ff;
  assign spr_wr_o       = spr_wr_ff;
  assign priv_exc_o     = priv_exc_ff;
  assign sync_o         = sync_ff;
  assign cr_o           = cr_ff;
  assign xer_o          = xer_ff;
  assign msr_o          = msr_ff;
endmodule // smx_exec

/* File: smx_exec_properties.sv */
// smx_exec_properties: port-level checks for smx_exec
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ps
module smx_exec_checker (
  input wire logic                    clk_i,
  input wire logic                    reset_i,
  input wire smx_pkg::smx_issue_t     issue_i,
  input wire logic [63:0]             time_base_i,
  input wire logic                    gpr_wr_valid_o,
  input wire logic [31:0]             gpr_wr_data_o,
  input wire smx_pkg::smx_sysreg_wr_t dcr_wr_o,
  input wire logic                    priv_exc_o,
  input wire logic                    sync_o,
  input wire logic [31:0]             cr_o,
  input wire logic [31:0]             xer_o,
  input wire logic [31:0]             msr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire [31:0] ins  = issue_i.instr;
  wire [9:0]  xo   = ins[10:1];
  wire [9:0]  swp  = {ins[15:11], ins[20:16]};
  wire        user = msr_o[smx_pkg::SMX_MSR_PR_BIT];
  wire        x31  = issue_i.valid && ins[31:26] == smx_pkg::SMX_OP_X31;
  wire        mac  = issue_i.valid && ins[31:26] == smx_pkg::SMX_OP_MAC && ins[9:1] == smx_pkg::SMX_XO_MACLHWU;
  wire [32:0] mac_sum = 33'(issue_i.src_a[15:0]) * 33'(issue_i.src_b[15:0]) + 33'(issue_i.dest_old);
  property p_mac;  mac |=> gpr_wr_valid_o && gpr_wr_data_o == $past(mac_sum[31:0]); endproperty
  property p_ovf;  mac && ins[10] && mac_sum[32] |=> xer_o[31:30] == 2'b11; endproperty
  property p_xclr; x31 && xo == smx_pkg::SMX_XO_MCRXR |=> xer_o[31:29] == 3'b000; endproperty
  property p_mfcr; x31 && xo == smx_pkg::SMX_XO_MFCR |=> gpr_wr_valid_o && gpr_wr_data_o == $past(cr_o); endproperty
  property p_mtdcr;
    x31 && !user && xo == smx_pkg::SMX_XO_MTDCR |=>
      dcr_wr_o.wr && dcr_wr_o.num == $past(swp) && dcr_wr_o.data == $past(issue_i.src_a);
  endproperty
  property p_priv;
    x31 && user && (xo == smx_pkg::SMX_XO_MFDCR || xo == smx_pkg::SMX_XO_MTDCR || xo == smx_pkg::SMX_XO_MFMSR)
      |=> priv_exc_o && !gpr_wr_valid_o && !dcr_wr_o.wr && msr_o == $past(msr_o);
  endproperty
  property p_mfmsr; x31 && !user && xo == smx_pkg::SMX_XO_MFMSR |=> gpr_wr_data_o == $past(msr_o); endproperty
  property p_mtmsr; x31 && !user && xo == smx_pkg::SMX_XO_MTMSR |=> sync_o && msr_o == $past(issue_i.src_a); endproperty
  property p_tbl;
    x31 && xo == smx_pkg::SMX_XO_MFTB && swp == smx_pkg::SMX_TBN_LOW |=> gpr_wr_data_o == $past(time_base_i[31:0]);
  endproperty
  a_mac:   assert property (p_mac) else $error("mac result wrong");
  a_ovf:   assert property (p_ovf) else $error("mac overflow flags wrong");
  a_xclr:  assert property (p_xclr) else $error("exception flags not cleared");
  a_mfcr:  assert property (p_mfcr) else $error("flag read wrong");
  a_mtdcr: assert property (p_mtdcr) else $error("device write wrong");
  a_priv:  assert property (p_priv) else $error("user access not refused");
  a_mfmsr: assert property (p_mfmsr) else $error("state read wrong");
  a_mtmsr: assert property (p_mtmsr) else $error("state write wrong");
  a_tbl:   assert property (p_tbl) else $error("time base low wrong");
  c_mac:   cover property (mac ##1 gpr_wr_valid_o);
  c_priv:  cover property (priv_exc_o);
  c_sync:  cover property (sync_o);
endmodule // smx_exec_checker
bind smx_exec smx_exec_checker chk_u (.clk_i(clk_i), .reset_i(reset_i), .issue_i(issue_i),
  .time_base_i(time_base_i), .gpr_wr_valid_o(gpr_wr_valid_o), .gpr_wr_data_o(gpr_wr_data_o),
  .dcr_wr_o(dcr_wr_o), .priv_exc_o(priv_exc_o), .sync_o(sync_o), .cr_o(cr_o), .xer_o(xer_o), .msr_o(msr_o));

/* File: tb_sysreg_move_and_mac_execute.sv */
// tb_sysreg_move_and_mac_execute: directed scenarios for smx_exec
// assumes smx_pkg is compiled first; inputs change on the falling edge
`timescale 1ns/1ps
module tb_sysreg_move_and_mac_execute;
  logic clk_i, reset_i, gv, pe, sy;
  smx_pkg::smx_issue_t     issue_i;
  smx_pkg::smx_sysreg_wr_t dw, sw;
  logic [4:0]  gi;
  logic [9:0]  dn, sn;
  logic [31:0] gd, cr_o, xer_o, msr_o, cr_e;
  int          err_total, total_checks;
  wire  [63:0] tb_v = 64'h0102_0304_0506_0708;
  smx_exec dut_u (.clk_i(clk_i), .reset_i(reset_i), .issue_i(issue_i), .dcr_rdata_i(32'h1234_5678),
    .spr_rdata_i(32'h9abc_def0), .time_base_i(tb_v), .gpr_wr_valid_o(gv), .gpr_wr_idx_o(gi),
    .gpr_wr_data_o(gd), .dcr_rnum_o(dn), .spr_rnum_o(sn), .dcr_wr_o(dw), .spr_wr_o(sw),
    .priv_exc_o(pe), .sync_o(sy), .cr_o(cr_o), .xer_o(xer_o), .msr_o(msr_o));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // issue stays valid so consecutive calls run back to back
  task go(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b, input logic [31:0] d);
    issue_i = {1'b1, ins, a, b, d};
    @(negedge clk_i);
  endtask
  function logic [31:0] xf(input logic [9:0] xo, input logic [4:0] rt, input logic [9:0] f);
    return {smx_pkg::SMX_OP_X31, rt, f, xo, 1'b0};
  endfunction
  task t_mac;
    go({6'h04, 5'h03, 5'h01, 5'h02, 1'b0, smx_pkg::SMX_XO_MACLHWU, 1'b1}, 32'habcd_0003, 32'h1234_0004, 32'h7fff_fff0);
    chk(gd, 32'h7fff_fffc);
    chk(32'(gi), 32'h3);
    chk(32'(cr_o[31:28]), 32'h4);
    cr_e[31:28] = 4'h4;
    go({6'h04, 5'h03, 5'h01, 5'h02, 1'b1, smx_pkg::SMX_XO_MACLHWU, 1'b0}, 32'h5555_ffff, 32'h6666_ffff, 32'hffff_ffff);
    chk(gd, 32'hfffe_0000);
    chk(xer_o, 32'hc000_0000);
  endtask
  task t_cr;
    go(xf(smx_pkg::SMX_XO_MCRXR, 5'h0c, 10'h000), 32'h0, 32'h0, 32'h0);
    cr_e[19:16] = 4'hc;
    chk(cr_o, cr_e);
    chk(xer_o, 32'h0);
    go(xf(smx_pkg::SMX_XO_MTCRF, 5'h00, 10'h102), 32'ha5a5_a5a5, 32'h0, 32'h0);
    cr_e = (cr_e & 32'h0fff_fff0) | 32'ha000_0005;
    chk(cr_o, cr_e);
    go({6'h13, 5'h14, 5'h0c, 5'h00, smx_pkg::SMX_XO_MCRF, 1'b0}, 32'h0, 32'h0, 32'h0);
    cr_e[11:8] = cr_e[19:16];
    chk(cr_o, cr_e);
    go(xf(smx_pkg::SMX_XO_MFCR, 5'h07, 10'h000), 32'h0, 32'h0, 32'h0);
    chk(gd, cr_e);
    go(xf(smx_pkg::SMX_XO_MFCR, 5'h07, 10'h000) | 32'h0000_0001, 32'h0, 32'h0, 32'h0);
    chk(cr_o, cr_e);
  endtask
  task t_sys;
    go(xf(smx_pkg::SMX_XO_MFDCR, 5'h04, 10'h071), 32'h0, 32'h0, 32'h0);
    chk(gd, 32'h1234_5678);
    chk(32'(dn), 32'h223);
    go(xf(smx_pkg::SMX_XO_MTDCR, 5'h09, 10'h071), 32'hcafe_0001, 32'h0, 32'h0);
    chk(dw.data, 32'hcafe_0001);
    chk({dw.wr, 21'h0, dw.num}, 32'h8000_0223);
    go(xf(smx_pkg::SMX_XO_MFTB, 5'h01, 10'h188), 32'h0, 32'h0, 32'h0);
    chk(gd, 32'h0506_0708);
    go(xf(smx_pkg::SMX_XO_MFTB, 5'h01, 10'h1a8), 32'h0, 32'h0, 32'h0);
    chk(gd, 32'h0102_0304);
    go(xf(smx_pkg::SMX_XO_MFTB, 5'h01, 10'h3ff), 32'h0, 32'h0, 32'h0);
    chk(cr_o ^ xer_o ^ msr_o, cr_e);
    go(xf(smx_pkg::SMX_XO_MTMSR, 5'h02, 10'h000), 32'h0000_0010, 32'h0, 32'h0);
    chk(msr_o | 32'(sy), 32'h0000_0011);
    go(xf(smx_pkg::SMX_XO_MFMSR, 5'h05, 10'h000), 32'h0, 32'h0, 32'h0);
    chk(gd, 32'h0000_0010);
  endtask
  task t_user;
    go(xf(smx_pkg::SMX_XO_MTMSR, 5'h02, 10'h000), 32'h0000_4010, 32'h0, 32'h0);
    go(xf(smx_pkg::SMX_XO_MFDCR, 5'h04, 10'h071), 32'h0, 32'h0, 32'h0);
    chk({pe, gv}, 2'b10);
    go(xf(smx_pkg::SMX_XO_MTDCR, 5'h04, 10'h071), 32'h1, 32'h0, 32'h0);
    chk({pe, dw.wr}, 2'b10);
    go(xf(smx_pkg::SMX_XO_MFSPR, 5'h04, 10'h120), 32'h0, 32'h0, 32'h0);
    chk(gd | 32'(pe), 32'h9abc_def0);
    chk(32'(sn), 32'h009);
    go(xf(smx_pkg::SMX_XO_MFSPR, 5'h04, 10'h210), 32'h0, 32'h0, 32'h0);
    chk({pe, gv}, 2'b10);
    go(xf(smx_pkg::SMX_XO_MTSPR, 5'h04, 10'h210), 32'h7, 32'h0, 32'h0);
    chk({pe, sw.wr}, 2'b10);
    go(xf(smx_pkg::SMX_XO_MTSPR, 5'h04, 10'h120), 32'h7, 32'h0, 32'h0);
    chk({pe, sw.wr, 20'h0, sw.num}, 32'h4000_0009);
    go(xf(smx_pkg::SMX_XO_MTMSR, 5'h02, 10'h000), 32'h0, 32'h0, 32'h0);
    chk(msr_o | 32'(pe), 32'h0000_4011);
  endtask
  task summarize;
    if (err_total == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    reset_i = 1'b1;
    issue_i = '0;
    cr_e = 32'h0;
    err_total = 0;
    total_checks = 0;
    repeat (12) @(negedge clk_i);
    reset_i = 1'b0;
    chk(cr_o | xer_o | msr_o, 32'h0);
    t_mac;
    t_cr;
    t_sys;
    t_user;
    issue_i.valid = 1'b0;
    summarize;
  end
endmodule // tb_sysreg_move_and_mac_execute
